// *** ack_policy.v ***
// ack policy, transmit retry and ack diagnostics register bank
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ack_policy_defs.vh"
module ack_policy #(
    parameter CYCLE_CLKS = `ISO_CYCLE_NS / `CLK_PERIOD_NS
) (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire master_sel_n,
    input wire selfid_valid,
    output reg selfid_iso_out,
    input wire rx_req,
    input wire [3:0] rx_tcode,
    input wire rx_csr_type_err,
    input wire rx_buf_full,
    input wire rx_stored,
    output reg rx_ack_valid,
    output reg [3:0] rx_ack_code,
    output reg [1:0] rx_busy_phase,
    input wire [3:0] busy_retry_limit,
    input wire [11:0] busy_time_limit,
    input wire tx_go,
    input wire tx_internal,
    output reg tx_send,
    input wire tx_ack_valid,
    input wire [3:0] tx_ack_in,
    input wire tx_ack_parity_err,
    input wire tx_ack_timeout,
    input wire txi_ack_valid,
    input wire [3:0] txi_ack_in,
    input wire txi_ack_parity_err,
    input wire txi_ack_timeout
);
    localparam S_IDLE = 2'h0;
    localparam S_WAIT = 2'h1;
    localparam S_SPACE = 2'h2;
    reg [31:0] ctrl_q;
    reg single_packet_held_q;
    reg single_packet_release_q;
    reg [3:0] host_tx_ack_code_q;
    reg [1:0] host_tx_ack_result_q;
    reg host_tx_retry_exhausted_q;
    reg [3:0] internal_tx_ack_code_q;
    reg [1:0] internal_tx_ack_result_q;
    reg host_tx_busy_q;
    reg internal_busy_q;
    reg [1:0] st_q;
    reg [3:0] retry_cnt_q;
    reg [11:0] retry_time_q;
    reg [7:0] space_cnt_q;
    reg [15:0] cyc_div_q;
    reg msel_s1_q, msel_s2_q;
    reg dual_phase_q;
    wire [2:0] busy_ack_select = ctrl_q[`B_BUSY_HI:`B_BUSY_LO];
    wire single_packet_receive_mode = ctrl_q[`B_ONE_PKT];
    wire split_write_ack = ctrl_q[`B_SPLIT_WR];
    wire addr_error_ack_select = ctrl_q[`B_ADDR_ERR];
    wire auto_retry_enable = ctrl_q[`B_RETRY_EN];
    wire [7:0] retry_spacing_cycles = ctrl_q[`B_RINT_HI:`B_RINT_LO];
    wire wr_en = psel & penable & pwrite;
    wire sel_ctrl = (paddr == `OFF_PKT_CTRL);
    wire sel_diag = (paddr == `OFF_DIAG);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~sel_ctrl & ~sel_diag;
    wire cyc_tick = (cyc_div_q == CYCLE_CLKS - 1);
    ////////////////////////////////////////////////////////////
    // register reads
    always @* begin
        if (sel_ctrl) begin
            prdata = ctrl_q;
        end else if (sel_diag) begin
            // bits 23:22 stay zero: the internal fifo keeps no retry result here
            prdata = {6'h00, internal_busy_q, host_tx_busy_q, 2'h0, internal_tx_ack_result_q,
                      internal_tx_ack_code_q, host_tx_retry_exhausted_q, 1'b0, host_tx_ack_result_q,
                      host_tx_ack_code_q, 3'h0, single_packet_held_q, 3'h0, single_packet_release_q};
        end else begin
            prdata = 32'h0000_0000;
        end
    end
    ////////////////////////////////////////////////////////////
    // master-select pin comes from outside
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            msel_s1_q <= 1'b1;
            msel_s2_q <= 1'b1;
        end else if (ce) begin
            msel_s1_q <= master_sel_n;
            msel_s2_q <= msel_s1_q;
        end
    end
    ////////////////////////////////////////////////////////////
    // receive ack selection
    reg [3:0] busy_code;
    reg [3:0] ack_d;
    reg busy_now;
    reg is_req_nonwrite;
    reg is_write_req;
    always @* begin
        case (busy_ack_select[1:0])
            2'h0: busy_code = dual_phase_q ? `ACK_BUSY_B : `ACK_BUSY_A;
            2'h1: busy_code = `ACK_BUSY_A;
            2'h2: busy_code = `ACK_BUSY_B;
            default: busy_code = `ACK_BUSY_X;
        endcase
        busy_now = busy_ack_select[2] | rx_buf_full;
        if (single_packet_receive_mode) begin
            busy_now = single_packet_held_q | rx_buf_full;
        end
        is_write_req = (rx_tcode == `TC_WR_REQ) | (rx_tcode == `TC_WR_REQ_BLK);
        is_req_nonwrite = (rx_tcode == `TC_RD_REQ) | (rx_tcode == `TC_RD_REQ_BLK) |
                          (rx_tcode == `TC_LOCK_REQ);
        if (busy_now) begin
            ack_d = busy_code;
        end else if (rx_csr_type_err) begin
            ack_d = addr_error_ack_select ? `ACK_ADDR_ERR : `ACK_TYPE_ERR;
        end else if (is_write_req) begin
            ack_d = split_write_ack ? `ACK_PENDING : `ACK_COMPLETE;
        end else if (is_req_nonwrite) begin
            ack_d = `ACK_PENDING;
        end else begin
            ack_d = `ACK_COMPLETE;
        end
    end
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_ack_valid <= 1'b0;
            rx_ack_code <= `ACK_NONE;
            rx_busy_phase <= 2'h0;
            dual_phase_q <= 1'b0;
            selfid_iso_out <= 1'b0;
        end else if (ce) begin
            rx_ack_valid <= rx_req;
            selfid_iso_out <= selfid_valid & ctrl_q[`B_SELFID_OUT] & ~msel_s2_q;
            if (rx_req) begin
                rx_ack_code <= ack_d;
                rx_busy_phase <= {1'b0, dual_phase_q};
            end
            // dual-phase alternates phases once per iso cycle
            if (cyc_tick) begin
                dual_phase_q <= ~dual_phase_q;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    // control register and single-packet state
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `PKT_CTRL_RESET | ({24'h0, `RETRY_INT_RESET} << `B_RINT_LO);
            single_packet_held_q <= 1'b0;
            single_packet_release_q <= 1'b0;
        end else if (ce) begin
            if (wr_en && sel_ctrl) begin
                ctrl_q <= pwdata & `CTRL_WR_MASK;
            end
            single_packet_release_q <= wr_en & sel_diag & pwdata[`B_REL];
            // a new store wins over the release
            if (single_packet_receive_mode && rx_stored) begin
                single_packet_held_q <= 1'b1;
            end else if (single_packet_release_q) begin
                single_packet_held_q <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    // host transmit with automatic retry
    wire ack_is_busy = (tx_ack_in == `ACK_BUSY_X) | (tx_ack_in == `ACK_BUSY_A) | (tx_ack_in == `ACK_BUSY_B);
    wire limits_hit = (retry_cnt_q >= busy_retry_limit) | (retry_time_q >= busy_time_limit);
    wire [3:0] host_code_in = tx_ack_timeout ? `ACK_NONE : tx_ack_in;
    wire [1:0] host_res_in = tx_ack_timeout ? `ST_LOST : (tx_ack_parity_err ? `ST_PARITY : `ST_NORMAL);
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= S_IDLE;
            host_tx_busy_q <= 1'b0;
            tx_send <= 1'b0;
            host_tx_ack_code_q <= `ACK_NONE;
            host_tx_ack_result_q <= `ST_NORMAL;
            host_tx_retry_exhausted_q <= 1'b0;
            retry_cnt_q <= 4'h0;
            retry_time_q <= 12'h000;
            space_cnt_q <= 8'h00;
            cyc_div_q <= 16'h0000;
        end else if (ce) begin
            tx_send <= 1'b0;
            cyc_div_q <= cyc_tick ? 16'h0000 : cyc_div_q + 16'h0001;
            if (st_q != S_IDLE && cyc_tick && retry_time_q != 12'hfff) begin
                retry_time_q <= retry_time_q + 12'h001;
            end
            case (st_q)
                S_IDLE: begin
                    // go while busy is ignored; internal packets bypass the host flags
                    if (tx_go && !tx_internal) begin
                        host_tx_busy_q <= 1'b1;
                        host_tx_retry_exhausted_q <= 1'b0;
                        retry_cnt_q <= 4'h0;
                        retry_time_q <= 12'h000;
                        tx_send <= 1'b1;
                        st_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (tx_ack_valid || tx_ack_timeout) begin
                        if (!tx_ack_timeout && ack_is_busy && auto_retry_enable && !limits_hit) begin
                            retry_cnt_q <= retry_cnt_q + 4'h1;
                            space_cnt_q <= retry_spacing_cycles;
                            st_q <= S_SPACE;
                        end else begin
                            host_tx_ack_code_q <= host_code_in;
                            host_tx_ack_result_q <= host_res_in;
                            host_tx_retry_exhausted_q <= !tx_ack_timeout && ack_is_busy &&
                                                         auto_retry_enable && limits_hit;
                            host_tx_busy_q <= 1'b0;
                            st_q <= S_IDLE;
                        end
                    end
                end
                S_SPACE: begin
                    if (space_cnt_q == 8'h00) begin
                        tx_send <= 1'b1;
                        st_q <= S_WAIT;
                    end else if (cyc_tick) begin
                        space_cnt_q <= space_cnt_q - 8'h01;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////
    // internal fifo ack capture
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            internal_tx_ack_code_q <= `ACK_NONE;
            internal_tx_ack_result_q <= `ST_NORMAL;
            internal_busy_q <= 1'b0;
        end else if (ce) begin
            if (tx_go && tx_internal) begin
                internal_busy_q <= 1'b1;
            end else if (txi_ack_valid || txi_ack_timeout) begin
                internal_busy_q <= 1'b0;
                internal_tx_ack_code_q <= txi_ack_timeout ? `ACK_NONE : txi_ack_in;
                internal_tx_ack_result_q <= txi_ack_timeout ? `ST_LOST :
                                            (txi_ack_parity_err ? `ST_PARITY : `ST_NORMAL);
            end
        end
    end
endmodule
`default_nettype wire

// *** ack_policy_defs.vh ***
// register offsets, field positions, codes and reset values for the ack policy block
// What this block does
// - self-id iso output only when enable set and master-select pin low
// - low two busy-control bits choose dual-phase, busy A, busy B or busy X
// - outside single-packet mode, busy-control top bit clear: busy only on full buffer; set: busy always
// - single-packet mode with a stored packet forces busy for later packets until the release write
// - held flag set on entering single-packet state, cleared by release write
// - release bit clears itself after software writes one
// - write request gets complete or pending by split-write bit, busy if full
// - read/lock requests get pending or busy; responses complete or busy
// - core type error answered type error or address error by select bit
// - retry enable allows automatic busy retries using busy-timeout limits
// - retries spaced by interval field in 125 us cycles; zero retries at once
// - host ack code field uses the documented four-bit ack encoding
// - host ack code loaded when busy flag drops, held until next drop
// - host ack result two-bit: normal, parity error, lost
// - retry-exhausted set when count or time reaches its limit, held until next packet
// - internal-csr packets never update host ack result or exhausted bit
// - internal fifo ack code captured in its own four-bit field
// - host busy flag drops only after ack stored and retries finished
`ifndef ACK_POLICY_DEFS_VH
`define ACK_POLICY_DEFS_VH
`define OFF_PKT_CTRL 12'h010
`define OFF_DIAG 12'h014
`define PKT_CTRL_RESET 32'h0000_5000
`define CTRL_WR_MASK 32'h00ff_7f80
`define RETRY_INT_RESET 8'h01
`define B_SELFID_OUT 7
`define B_BUSY_LO 8
`define B_BUSY_HI 10
`define B_ONE_PKT 11
`define B_SPLIT_WR 12
`define B_ADDR_ERR 13
`define B_RETRY_EN 14
`define B_RINT_LO 16
`define B_RINT_HI 23
`define B_REL 0
`define B_HELD 4
`define ACK_NONE 4'h0
`define ACK_COMPLETE 4'h1
`define ACK_PENDING 4'h2
`define ACK_BUSY_X 4'h4
`define ACK_BUSY_A 4'h5
`define ACK_BUSY_B 4'h6
`define ACK_DATA_ERR 4'hd
`define ACK_TYPE_ERR 4'he
`define ACK_ADDR_ERR 4'hf
`define ST_NORMAL 2'h0
`define ST_PARITY 2'h1
`define ST_LOST 2'h2
`define TC_WR_REQ 4'h0
`define TC_WR_REQ_BLK 4'h1
`define TC_WR_RESP 4'h2
`define TC_RD_REQ 4'h4
`define TC_RD_REQ_BLK 4'h5
`define TC_RD_RESP 4'h6
`define TC_RD_RESP_BLK 4'h7
`define TC_LOCK_REQ 4'h9
`define TC_LOCK_RESP 4'hb
`define ISO_CYCLE_NS 125000
`define CLK_PERIOD_NS 100
`endif

// *** ack_policy_monitor.sv ***
// assertion checker bound to the ack policy block
`timescale 1ns/1ps
`default_nettype none
`include "ack_policy_defs.vh"
module ack_policy_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic master_sel_n,
    input wire logic selfid_valid,
    input wire logic selfid_iso_out,
    input wire logic rx_req,
    input wire logic [3:0] rx_tcode,
    input wire logic rx_csr_type_err,
    input wire logic rx_buf_full,
    input wire logic rx_ack_valid,
    input wire logic [3:0] rx_ack_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_ack_follow; rx_req |=> rx_ack_valid; endproperty
    a_ack_follow: assert property (p_ack_follow) else $error("no ack one cycle after request");
    property p_ack_cause; rx_ack_valid |-> $past(rx_req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_full_busy; rx_req && rx_buf_full |=> rx_ack_code inside {4'h4, 4'h5, 4'h6}; endproperty
    a_full_busy: assert property (p_full_busy) else $error("full buffer not answered busy");
    // busy may still win over a type error, so it stays allowed here
    property p_type_err; rx_req && !rx_buf_full && rx_csr_type_err |=> rx_ack_code inside {4'h4, 4'h5, 4'h6, 4'he, 4'hf};
    endproperty
    a_type_err: assert property (p_type_err) else $error("type error answered wrongly");
    property p_rd_req; rx_req && !rx_csr_type_err && rx_tcode inside {4'h4, 4'h5, 4'h9}
        |=> rx_ack_code inside {4'h2, 4'h4, 4'h5, 4'h6}; endproperty
    a_rd_req: assert property (p_rd_req) else $error("read or lock request not pending or busy");
    property p_resp; rx_req && !rx_csr_type_err && rx_tcode inside {4'h2, 4'h6, 4'h7, 4'hb}
        |=> rx_ack_code inside {4'h1, 4'h4, 4'h5, 4'h6}; endproperty
    a_resp: assert property (p_resp) else $error("response not complete or busy");
    property p_wr_req; rx_req && !rx_csr_type_err && rx_tcode inside {4'h0, 4'h1}
        |=> rx_ack_code inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6}; endproperty
    a_wr_req: assert property (p_wr_req) else $error("write request answered wrongly");
    property p_no_rsv; rx_ack_valid |-> !(rx_ack_code inside {4'h0, 4'h3, [4'h7:4'hc]}); endproperty
    a_no_rsv: assert property (p_no_rsv) else $error("reserved ack code sent");
    property p_sid_off; master_sel_n [*4] |-> !selfid_iso_out; endproperty
    a_sid_off: assert property (p_sid_off) else $error("self-id output in slave mode");
    property p_sid_on; selfid_iso_out |-> $past(selfid_valid); endproperty
    a_sid_on: assert property (p_sid_on) else $error("self-id output without data");
endmodule
bind ack_policy ack_policy_monitor i_ack_policy_monitor (.clk, .nrst, .master_sel_n, .selfid_valid,
    .selfid_iso_out, .rx_req, .rx_tcode, .rx_csr_type_err, .rx_buf_full, .rx_ack_valid, .rx_ack_code);
`default_nettype wire

// *** remote_node.sv ***
// remote node model answering the block's transmissions
`timescale 1ns/1ps
`default_nettype none
module remote_node (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tx_send,
    input wire logic slow,
    input wire logic [1:0] reply_kind,
    input wire logic [3:0] reply_code,
    output logic ack_valid,
    output logic [3:0] ack_code,
    output logic parity_err,
    output logic no_ack
);
    logic [2:0] wait_q;
    wire fire = (wait_q == 3'h1);
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 3'h0;
            ack_valid <= 1'b0;
            ack_code <= 4'h0;
            parity_err <= 1'b0;
            no_ack <= 1'b0;
        end else begin
            wait_q <= tx_send ? (slow ? 3'h6 : 3'h1) : (wait_q != 3'h0 ? wait_q - 3'h1 : 3'h0);
            ack_valid <= fire && reply_kind != 2'h2;
            parity_err <= fire && reply_kind == 2'h1;
            no_ack <= fire && reply_kind == 2'h2;
            // outside the answer the code lines wander, never holding the last value
            ack_code <= fire ? reply_code : ~ack_code;
        end
    end
endmodule
`default_nettype wire

// *** tb_ack_policy.sv ***
// self-checking testbench for the ack policy block
`timescale 1ns/1ps
`default_nettype none
`include "ack_policy_defs.vh"
module tb_ack_policy;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, master_sel_n = 1'b1;
    logic selfid_valid = 1'b0, rx_req = 1'b0, rx_csr_type_err = 1'b0, rx_buf_full = 1'b0, rx_stored = 1'b0;
    logic tx_go = 1'b0, intl = 1'b0, slow = 1'b0, ce = 1'b1, se;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [3:0] rx_tcode = 4'h0, rcode = 4'h1;
    logic [1:0] rkind = 2'h0;
    wire [31:0] prdata;
    wire pready, pslverr, selfid_iso_out, rx_ack_valid, tx_send, pv, ppe, pto;
    wire [3:0] rx_ack_code, pc;
    wire [1:0] bph;
    int err_count = 0, n_tests = 0, sends = 0;
    ack_policy #(.CYCLE_CLKS(10)) i_ack_policy (.clk, .nrst, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .master_sel_n, .selfid_valid, .selfid_iso_out, .rx_req, .rx_tcode,
        .rx_csr_type_err, .rx_buf_full, .rx_stored, .rx_ack_valid, .rx_ack_code, .rx_busy_phase(bph),
        .busy_retry_limit(4'h1), .busy_time_limit(12'h00f), .tx_go, .tx_internal(intl), .tx_send,
        .tx_ack_valid(pv & !intl), .tx_ack_in(pc), .tx_ack_parity_err(ppe & !intl), .tx_ack_timeout(pto & !intl),
        .txi_ack_valid(pv & intl), .txi_ack_in(pc), .txi_ack_parity_err(ppe & intl), .txi_ack_timeout(pto & intl));
    // the internal fifo starts its own send, the block pulses tx_send for host packets only
    remote_node i_remote_node (.clk, .nrst, .tx_send(tx_send | (tx_go & intl)), .slow, .reply_kind(rkind),
        .reply_code(rcode),
        .ack_valid(pv), .ack_code(pc), .parity_err(ppe), .no_ack(pto));
    always #50 clk = ~clk;
    always @(posedge clk) if (tx_send) sends++;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // exp of zero stands for either half of the dual-phase busy pair
    task automatic rx(input logic [3:0] tc, input logic te, input logic [3:0] exp);
        rx_req <= 1'b1;
        rx_tcode <= tc;
        rx_csr_type_err <= te;
        @(posedge clk);
        rx_req <= 1'b0;
        #1;
        chk(rx_ack_valid, 1);
        if (exp == 4'h0) chk(rx_ack_code inside {`ACK_BUSY_A, `ACK_BUSY_B}, 1);
        if (exp == 4'h0) chk(rx_ack_code, bph[0] ? `ACK_BUSY_B : `ACK_BUSY_A);
        else chk(rx_ack_code, exp);
        @(posedge clk);
    endtask
    task automatic tx(input logic i, input logic [1:0] k, input logic [3:0] c, input logic [31:0] m, e);
        intl <= i;
        rkind <= k;
        rcode <= c;
        tx_go <= 1'b1;
        sends = 0;
        @(posedge clk);
        tx_go <= 1'b0;
        do apb(0, `OFF_DIAG, 0); while (rd[25:24] !== 2'h0);
        chk(rd & m, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [3:0] lut [4] = '{4'h0, `ACK_BUSY_A, `ACK_BUSY_B, `ACK_BUSY_X};
        apb(0, `OFF_PKT_CTRL, 0);
        chk(rd, 32'h0001_5000);
        apb(0, `OFF_DIAG, 0);
        chk(rd, 32'h0);
        apb(1, 12'h0f0, 32'hffff_ffff);
        chk(se, 1);
        // frozen clock enable must swallow the write
        ce <= 1'b0;
        apb(1, `OFF_PKT_CTRL, 32'hffff_ffff);
        ce <= 1'b1;
        apb(0, `OFF_PKT_CTRL, 0);
        chk(rd, 32'h0001_5000);
        for (int b = 0; b < 8; b++) begin
            apb(1, `OFF_PKT_CTRL, b << 8);
            rx_buf_full <= (b < 4);
            rx(`TC_WR_REQ, 0, lut[b % 4]);
        end
        rx_buf_full <= 1'b0;
        $display("register and busy control test done");
    endtask
    task automatic t_types;
        logic [3:0] tcs [6] = '{`TC_WR_REQ, `TC_RD_REQ, `TC_WR_RESP, `TC_RD_RESP, `TC_LOCK_REQ, `TC_LOCK_RESP};
        logic [3:0] exs [6] = '{4'h1, 4'h2, 4'h1, 4'h1, 4'h2, 4'h1};
        for (int s = 0; s < 2; s++) begin
            apb(1, `OFF_PKT_CTRL, (s << 12) | (s << 13) | 32'h100);
            for (int i = 0; i < 6; i++) rx(tcs[i], 0, (i == 0 && s == 1) ? `ACK_PENDING : exs[i]);
            rx(`TC_WR_REQ, 1, s ? `ACK_ADDR_ERR : `ACK_TYPE_ERR);
            if (s) tx(0, 2'h0, `ACK_COMPLETE, 32'h0000_0f00, 32'h0000_0100);
        end
        $display("ack type test done");
    endtask
    task automatic t_one;
        apb(1, `OFF_PKT_CTRL, 32'h0000_0800);
        rx(`TC_WR_REQ, 0, `ACK_COMPLETE);
        rx_stored <= 1'b1;
        @(posedge clk);
        rx_stored <= 1'b0;
        apb(0, `OFF_DIAG, 0);
        chk(rd[4], 1);
        rx(`TC_RD_REQ, 0, 4'h0);
        apb(1, `OFF_DIAG, 32'h1);
        apb(0, `OFF_DIAG, 0);
        chk(rd[4:0], 5'h0);
        rx(`TC_RD_REQ, 0, `ACK_PENDING);
        apb(1, `OFF_PKT_CTRL, 32'h0000_0080);
        master_sel_n <= 1'b0;
        selfid_valid <= 1'b1;
        repeat (5) @(posedge clk);
        chk(selfid_iso_out, 1);
        master_sel_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk(selfid_iso_out, 0);
        selfid_valid <= 1'b0;
        $display("single packet and self-id test done");
    endtask
    task automatic t_tx;
        apb(1, `OFF_PKT_CTRL, 32'h0);
        tx(0, 2'h0, `ACK_COMPLETE, 32'h0000_bf00, 32'h0000_0100);
        tx(0, 2'h1, `ACK_COMPLETE, 32'h0000_3000, 32'h0000_1000);
        tx(0, 2'h2, `ACK_COMPLETE, 32'h0000_bf00, 32'h0000_2000);
        tx(1, 2'h0, `ACK_PENDING, 32'h000f_bf00, 32'h0002_2000);
        tx(0, 2'h0, `ACK_BUSY_A, 32'h0000_0f00, 32'h0000_0500);
        chk(sends, 1);
        apb(1, `OFF_PKT_CTRL, 32'h0000_4000);
        slow <= 1'b1;
        tx(0, 2'h0, `ACK_BUSY_B, 32'h0000_8f00, 32'h0000_8600);
        chk(sends > 1, 1);
        $display("transmit test done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_regs();
        t_types();
        t_one();
        t_tx();
        test_done();
    end
    // a hang in any handshake wait ends here
    initial begin
        #2_000_000;
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
